// file: core/jlsb_pkg.sv
// How it works
// - soft reset command at control register resets device within the wait interval
// - all-ones alignment write forces internal alignment; controller then waits six lmfcs
// - subclass 1 nyquist: sysref sets lmfc, then adjust writes, wait, receiver on
// - harmonic bring-up: power down by pin or power-mode value, both honoured
// - clock divide setting takes effect on the transfer commit write; soft reset reloads the default divide
// - with sysref buffer enable cleared, external sysref is ignored entirely
// - phases cgs, ilas, data; scrambling applied only in data phase
// - code group sync sends only the comma character continuously
// - subclass 1 sysref edge sets lmfc and resets sampling phase
// - ilas starts next clock or next lmfc boundary; exactly four multiframes
// - multiframes one, three, four start with R and end with A
// - multiframe two: R, Q, fourteen config octets, then A at end
// - config octets 0 to 6: did, bid, lid, scr with l-1, f-1, k-1, m-1
// - octets 7 to 13: cs/n-1, subclass/n'-1, version/s-1, hd/cf, reserved, checksum
// - many config parameters are sent as value minus one
// - data phase replaces frame-end octet by previous-match or trigger value rules
// - replacement uses A at multiframe end and F at other frame ends
// - link-disable bit set holds link disabled and in reset
// - clearing link-disable releases link and starts synchronisation
package jlsb_pkg;
  // register offsets
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h00;
  localparam logic [7:0] ADDR_POWER_MODE = 8'h08;
  localparam logic [7:0] ADDR_CLK_DIV = 8'h0b;
  localparam logic [7:0] ADDR_REF_SYNC = 8'h3a;
  localparam logic [7:0] ADDR_LINK_CTRL = 8'h5f;
  localparam logic [7:0] ADDR_ADJ_FIRST = 8'hee;
  localparam logic [7:0] ADDR_ADJ_SECOND = 8'hef;
  localparam logic [7:0] ADDR_ALIGN = 8'hf3;
  localparam logic [7:0] ADDR_COMMIT = 8'hff;
  // command values
  localparam logic [7:0] CMD_SOFT_RESET = 8'h3c;
  localparam logic [7:0] CMD_POWER_DOWN = 8'h05;
  localparam logic [7:0] CMD_COMMIT = 8'h01;
  localparam logic [7:0] CMD_ALIGN = 8'hff;
  // field positions
  localparam int REF_CONT_BIT = 2;
  localparam int REF_BUF_EN_BIT = 0;
  localparam int LINK_DIS_BIT = 0;
  // reset values
  localparam logic [7:0] RST_POWER_MODE = 8'h00;
  localparam logic [7:0] RST_CLK_DIV = 8'h00;
  localparam logic [7:0] RST_REF_SYNC = 8'h01;
  localparam logic [7:0] RST_LINK_CTRL = 8'h00;
  localparam logic [7:0] RST_ADJ = 8'h00;
  // control characters
  localparam logic [7:0] K_COMMA = 8'hbc;
  localparam logic [7:0] K_START_MF = 8'h1c;
  localparam logic [7:0] K_LANE_ALIGN = 8'h7c;
  localparam logic [7:0] K_CFG_MARK = 8'h9c;
  localparam logic [7:0] K_FRAME_ALIGN = 8'hfc;
  // link parameters, true values
  localparam int P_L = 2;
  localparam int P_F = 2;
  localparam int P_K = 32;
  localparam int P_M = 2;
  localparam int P_N = 11;
  localparam int P_NP = 16;
  localparam int P_S = 1;
  localparam int P_JESDV = 1;
  localparam int P_HD = 0;
  localparam int P_CF = 0;
  localparam logic [5:0] MF_LAST_POS = 6'(P_K * P_F - 1);
  localparam logic [7:0] ILAS_LAST_POS = 8'(4 * P_K * P_F - 1);
  localparam logic [5:0] CFG_FIRST_POS = 6'h02;
  localparam logic [5:0] CFG_LAST_POS = 6'h0f;
  // timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int SOFT_RST_TIME_US = 500;
  localparam int SOFT_RST_CYCLES = (SOFT_RST_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef enum logic [1:0] {PH_OFF, PH_CGS, PH_ILAS, PH_DATA} jlsb_phase_t;

  typedef struct packed {
    logic k;
    logic [7:0] d;
  } jlsb_lane_sym_t;

  typedef jlsb_lane_sym_t [1:0] jlsb_lane_pair_t;

  typedef struct packed {
    logic [7:0] did;
    logic [3:0] bid;
    logic scr_en;
    logic [2:0] subclass;
    logic [1:0] cs;
  } jlsb_link_cfg_t;

  typedef struct packed {
    logic [14:0] hist;
  } jlsb_scr_state_t;
endpackage : jlsb_pkg

// file: core/jlsb_scrambler.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// self-synchronous 1 + x^14 + x^15 scrambler, one octet per clock, msb first
module jlsb_scrambler (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic adv_in,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out
);
  import jlsb_pkg::*;

  jlsb_scr_state_t s_reg;
  jlsb_scr_state_t s_next;

  always_comb begin
    logic [14:0] h;
    logic b;
    h = s_reg.hist;
    b = 1'b0;
    data_out = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      b = data_in[i] ^ h[13] ^ h[14];
      data_out[i] = b;
      h = {h[13:0], b};
    end
    s_next.hist = adv_in ? h : 15'h0000;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  a_scr_idle_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !adv_in |=> s_reg.hist == 15'h0000)
    else $error("scrambler history not cleared outside data phase");
endmodule : jlsb_scrambler

// file: core/jlsb_link_top.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// link bring-up registers, cgs/ilas/data sequencer and character replacement
module jlsb_link_top #(
  parameter int SOFT_RST_CYCLES_P = jlsb_pkg::SOFT_RST_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic power_down_pin_in,
  input wire logic sysref_in,
  input wire logic sync_n_in,
  input wire logic [15:0] adc_a_in,
  input wire logic [15:0] adc_b_in,
  input wire jlsb_pkg::jlsb_link_cfg_t cfg_in,
  output jlsb_pkg::jlsb_lane_pair_t lane_sym_out,
  output jlsb_pkg::jlsb_phase_t link_phase_out,
  output logic [7:0] reg_rdata_out,
  output logic [7:0] clk_div_active_out,
  output logic powered_down_out,
  output logic soft_reset_busy_out,
  output logic sample_phase_reset_out
);
  import jlsb_pkg::*;

  typedef struct packed {
    jlsb_phase_t phase;
    logic [5:0] lmfc;
    logic [7:0] pos;
    logic [1:0][7:0] prev_last;
    logic [1:0][7:0] lo_hold;
    jlsb_lane_pair_t sym;
    logic [16:0] srst_cnt;
    logic [7:0] pmode;
    logic [7:0] div_stage;
    logic [7:0] div_act;
    logic [7:0] refopt;
    logic [7:0] linkctl;
    logic [7:0] adj1;
    logic [7:0] adj2;
    logic [7:0] rdata;
    logic sysref_d;
    logic phase_rst;
  } jlsb_top_state_t;

  logic rst_meta_reg;
  logic rst_n;
  jlsb_top_state_t s_reg;
  jlsb_top_state_t s_next;
  logic [1:0][7:0] raw_oct;
  logic [1:0][7:0] scr_oct;
  logic scr_adv;
  logic busy;
  logic hold;
  logic sref_edge;
  logic align_wr;

  ////////////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // configuration octets, l, f, k, m, n, n' and s sent minus one
  function automatic logic [7:0] cfg_octet(input logic [3:0] idx, input logic [4:0] lid,
                                           input jlsb_link_cfg_t c);
    logic [7:0] sum;
    sum = c.did + {4'h0, c.bid} + {3'h0, lid} + {7'h00, c.scr_en} + 8'(P_L - 1)
        + 8'(P_F - 1) + 8'(P_K - 1) + 8'(P_M - 1) + {6'h00, c.cs} + 8'(P_N - 1)
        + {5'h00, c.subclass} + 8'(P_NP - 1) + 8'(P_JESDV) + 8'(P_S - 1)
        + 8'(P_HD) + 8'(P_CF);
    case (idx)
      4'h0: cfg_octet = c.did;
      4'h1: cfg_octet = {4'h0, c.bid};
      4'h2: cfg_octet = {3'h0, lid};
      4'h3: cfg_octet = {c.scr_en, 2'b00, 5'(P_L - 1)};
      4'h4: cfg_octet = 8'(P_F - 1);
      4'h5: cfg_octet = {3'h0, 5'(P_K - 1)};
      4'h6: cfg_octet = 8'(P_M - 1);
      4'h7: cfg_octet = {c.cs, 1'b0, 5'(P_N - 1)};
      4'h8: cfg_octet = {c.subclass, 5'(P_NP - 1)};
      4'h9: cfg_octet = {3'(P_JESDV), 5'(P_S - 1)};
      4'ha: cfg_octet = {1'(P_HD), 2'b00, 5'(P_CF)};
      4'hd: cfg_octet = sum;
      default: cfg_octet = 8'h00;
    endcase
  endfunction : cfg_octet

  ////////////////////////////////////////////////////////////////////////////////
  // per-lane scramblers
  assign scr_adv = (s_reg.phase == PH_DATA) && cfg_in.scr_en;

  for (genvar l = 0; l < 2; l++) begin : g_lane
    assign raw_oct[l] = s_reg.pos[0] ? s_reg.lo_hold[l]
                                     : (l == 0 ? adc_a_in[15:8] : adc_b_in[15:8]);
    jlsb_scrambler u_scr (
      .clk_in(sys_clk_in),
      .rst_n_in(rst_n),
      .adv_in(scr_adv),
      .data_in(raw_oct[l]),
      .data_out(scr_oct[l])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  assign busy = s_reg.srst_cnt != 17'h00000;
  assign hold = s_reg.linkctl[LINK_DIS_BIT] || busy || powered_down_out;
  assign sref_edge = sysref_in && !s_reg.sysref_d && s_reg.refopt[REF_BUF_EN_BIT]
                     && (cfg_in.subclass != 3'h0);
  assign align_wr = reg_wr_in && !busy && reg_addr_in == ADDR_ALIGN
                    && reg_wdata_in == CMD_ALIGN;

  always_comb begin
    logic [5:0] p6;
    logic [7:0] oct;
    logic mf_end;
    p6 = s_reg.pos[5:0];
    oct = 8'h00;
    mf_end = 1'b0;
    s_next = s_reg;
    s_next.sysref_d = sysref_in;
    s_next.phase_rst = sref_edge;
    s_next.lmfc = (align_wr || sref_edge) ? 6'h00 : s_reg.lmfc + 6'h01;
    if (busy) begin
      s_next.srst_cnt = s_reg.srst_cnt - 17'h00001;
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        ADDR_SOFT_RESET: s_next.rdata = {7'h00, busy};
        ADDR_POWER_MODE: s_next.rdata = s_reg.pmode;
        ADDR_CLK_DIV: s_next.rdata = s_reg.div_stage;
        ADDR_REF_SYNC: s_next.rdata = s_reg.refopt;
        ADDR_LINK_CTRL: s_next.rdata = s_reg.linkctl;
        ADDR_ADJ_FIRST: s_next.rdata = s_reg.adj1;
        ADDR_ADJ_SECOND: s_next.rdata = s_reg.adj2;
        ADDR_COMMIT: s_next.rdata = s_reg.div_act;
        default: s_next.rdata = 8'h00;
      endcase
    end
    if (reg_wr_in && !busy) begin
      case (reg_addr_in)
        ADDR_SOFT_RESET: begin
          if (reg_wdata_in == CMD_SOFT_RESET) begin
            s_next.srst_cnt = 17'(SOFT_RST_CYCLES_P);
            s_next.pmode = RST_POWER_MODE;
            s_next.div_stage = RST_CLK_DIV;
            s_next.div_act = RST_CLK_DIV;
            s_next.refopt = RST_REF_SYNC;
            s_next.linkctl = RST_LINK_CTRL;
            s_next.adj1 = RST_ADJ;
            s_next.adj2 = RST_ADJ;
          end
        end
        ADDR_POWER_MODE: s_next.pmode = reg_wdata_in;
        ADDR_CLK_DIV: s_next.div_stage = reg_wdata_in;
        ADDR_REF_SYNC: s_next.refopt = reg_wdata_in;
        ADDR_LINK_CTRL: s_next.linkctl = reg_wdata_in;
        ADDR_ADJ_FIRST: s_next.adj1 = reg_wdata_in;
        ADDR_ADJ_SECOND: s_next.adj2 = reg_wdata_in;
        ADDR_COMMIT: begin
          if (reg_wdata_in == CMD_COMMIT) begin
            s_next.div_act = s_reg.div_stage;
          end
        end
        default: ;
      endcase
    end
    // phase sequencing
    if (hold) begin
      s_next.phase = PH_OFF;
      s_next.pos = 8'h00;
    end else begin
      case (s_reg.phase)
        PH_OFF: s_next.phase = PH_CGS;
        PH_CGS: begin
          if (sync_n_in && (cfg_in.subclass == 3'h0 || s_reg.lmfc == MF_LAST_POS)) begin
            s_next.phase = PH_ILAS;
            s_next.pos = 8'h00;
          end
        end
        PH_ILAS: begin
          s_next.pos = s_reg.pos + 8'h01;
          if (!sync_n_in) begin
            s_next.phase = PH_CGS;
          end else if (s_reg.pos == ILAS_LAST_POS) begin
            s_next.phase = PH_DATA;
            s_next.pos = 8'h00;
          end
        end
        PH_DATA: begin
          s_next.pos = {2'b00, p6 + 6'h01};
          if (!sync_n_in) begin
            s_next.phase = PH_CGS;
          end
        end
        default: s_next.phase = PH_OFF;
      endcase
    end
    // lane symbols
    for (int l = 0; l < 2; l++) begin
      case (s_reg.phase)
        PH_CGS: s_next.sym[l] = '{k: 1'b1, d: K_COMMA};
        PH_ILAS: begin
          if (p6 == 6'h00) begin
            s_next.sym[l] = '{k: 1'b1, d: K_START_MF};
          end else if (p6 == MF_LAST_POS) begin
            s_next.sym[l] = '{k: 1'b1, d: K_LANE_ALIGN};
          end else if (s_reg.pos[7:6] == 2'b01 && p6 == 6'h01) begin
            s_next.sym[l] = '{k: 1'b1, d: K_CFG_MARK};
          end else if (s_reg.pos[7:6] == 2'b01 && p6 >= CFG_FIRST_POS && p6 <= CFG_LAST_POS) begin
            s_next.sym[l] = '{k: 1'b0,
                              d: cfg_octet(4'(p6 - CFG_FIRST_POS), 5'(l), cfg_in)};
          end else begin
            s_next.sym[l] = '{k: 1'b0, d: {2'b00, p6}};
          end
        end
        PH_DATA: begin
          oct = cfg_in.scr_en ? scr_oct[l] : raw_oct[l];
          mf_end = p6 == MF_LAST_POS;
          s_next.sym[l] = '{k: 1'b0, d: oct};
          if (!s_reg.pos[0]) begin
            s_next.lo_hold[l] = (l == 0) ? adc_a_in[7:0] : adc_b_in[7:0];
          end else begin
            s_next.prev_last[l] = oct;
            if (cfg_in.scr_en) begin
              if ((mf_end && oct == K_LANE_ALIGN) || (!mf_end && oct == K_FRAME_ALIGN)) begin
                s_next.sym[l].k = 1'b1;
              end
            end else if (oct == s_reg.prev_last[l]) begin
              s_next.sym[l] = '{k: 1'b1,
                                d: mf_end ? K_LANE_ALIGN : K_FRAME_ALIGN};
            end
          end
        end
        default: s_next.sym[l] = '{k: 1'b0, d: 8'h00};
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '{phase: PH_OFF, pmode: RST_POWER_MODE, div_stage: RST_CLK_DIV,
                 div_act: RST_CLK_DIV, refopt: RST_REF_SYNC, linkctl: RST_LINK_CTRL,
                 adj1: RST_ADJ, adj2: RST_ADJ, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign lane_sym_out = s_reg.sym;
  assign link_phase_out = s_reg.phase;
  assign reg_rdata_out = s_reg.rdata;
  assign clk_div_active_out = s_reg.div_act;
  assign powered_down_out = power_down_pin_in || s_reg.pmode == CMD_POWER_DOWN;
  assign soft_reset_busy_out = busy;
  assign sample_phase_reset_out = s_reg.phase_rst;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n);

  a_cgs_comma_only: assert property (s_reg.phase == PH_CGS && !hold |=>
    lane_sym_out[0] == {1'b1, K_COMMA} && lane_sym_out[1] == {1'b1, K_COMMA})
    else $error("cgs phase sent something other than comma");
  a_disable_holds: assert property (s_reg.linkctl[LINK_DIS_BIT] |=>
    s_reg.phase == PH_OFF) else $error("link not held while disabled");
  a_enable_starts: assert property (s_reg.phase == PH_OFF && !hold |=>
    s_reg.phase == PH_CGS) else $error("link did not start after enable");
  a_sub0_ilas_start: assert property (s_reg.phase == PH_CGS && !hold && sync_n_in
    && cfg_in.subclass == 3'h0 |=> s_reg.phase == PH_ILAS)
    else $error("subclass 0 ilas did not start next clock");
  a_sub1_ilas_wait: assert property (s_reg.phase == PH_CGS && cfg_in.subclass != 3'h0
    && s_reg.lmfc != MF_LAST_POS |=> s_reg.phase != PH_ILAS)
    else $error("subclass 1 ilas started off lmfc boundary");
  a_ilas_four_mf: assert property ($rose(s_reg.phase == PH_DATA) |->
    $past(s_reg.pos) == ILAS_LAST_POS) else $error("ilas length not four multiframes");
  a_ilas_mf_chars: assert property (s_reg.phase == PH_ILAS && !hold
    && s_reg.pos[5:0] == 6'h00 ##1 1'b1 |-> lane_sym_out[0] == {1'b1, K_START_MF})
    else $error("multiframe does not begin with start character");
  a_ilas_cfg_mark: assert property (s_reg.phase == PH_ILAS && !hold
    && s_reg.pos == 8'h41 |=> lane_sym_out[1] == {1'b1, K_CFG_MARK})
    else $error("second multiframe lacks configuration marker");
  a_div_commit: assert property ($changed(s_reg.div_act) |->
    $past(reg_wr_in && !busy && ((reg_addr_in == ADDR_COMMIT && reg_wdata_in == CMD_COMMIT)
    || (reg_addr_in == ADDR_SOFT_RESET && reg_wdata_in == CMD_SOFT_RESET))))
    else $error("clock divider applied without commit");
  a_sysref_gated: assert property (sample_phase_reset_out |->
    $past(s_reg.refopt[REF_BUF_EN_BIT]) && s_reg.lmfc == 6'h00)
    else $error("sysref acted while buffer disabled or lmfc not reset");
  a_soft_rst_busy: assert property (reg_wr_in && !busy && reg_addr_in == ADDR_SOFT_RESET
    && reg_wdata_in == CMD_SOFT_RESET |=> busy [*8]) else $error("soft reset not held");
  a_align_lmfc: assert property (align_wr |=> s_reg.lmfc == 6'h00)
    else $error("alignment write did not restart lmfc");

  c_reach_data: cover property (s_reg.phase == PH_ILAS ##1 s_reg.phase == PH_DATA);
  c_sysref_align: cover property (sample_phase_reset_out);
  c_char_replace: cover property (s_reg.phase == PH_DATA ##1 lane_sym_out[0].k);
  c_soft_reset: cover property ($fell(busy));
endmodule : jlsb_link_top

// file: dv/jlsb_rx_model.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// far-end receiver: locks on commas, sends one sysref in subclass 1, raises sync_n
module jlsb_rx_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire jlsb_pkg::jlsb_lane_pair_t lane_sym_in,
  input wire logic subclass1_in,
  input wire logic resync_in,
  output logic sync_n_out = 1'b0,
  output logic sysref_out = 1'b0
);
  import jlsb_pkg::*;
  logic [2:0] comma_cnt = 3'h0;
  logic [5:0] lmfc = 6'h00;
  logic sent = 1'b0;
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync_n_out <= 1'b0;
      sysref_out <= 1'b0;
      comma_cnt <= 3'h0;
      sent <= 1'b0;
    end else begin
      lmfc <= lmfc + 6'h01;
      if (sysref_out && lmfc == 6'h01) sysref_out <= 1'b0;
      if (resync_in) begin
        sync_n_out <= 1'b0;
        comma_cnt <= 3'h0;
        sent <= 1'b0;
      end else if (!sync_n_out) begin
        if (lane_sym_in[0] != {1'b1, K_COMMA}) comma_cnt <= 3'h0;
        else if (comma_cnt != 3'h4) comma_cnt <= comma_cnt + 3'h1;
        if (comma_cnt == 3'h4) begin
          if (!subclass1_in) sync_n_out <= 1'b1;
          else if (!sent) begin
            sysref_out <= 1'b1;
            sent <= 1'b1;
            lmfc <= 6'h00;
          end else if (lmfc == 6'h3f) sync_n_out <= 1'b1;
        end
      end
    end
  end
endmodule : jlsb_rx_model

// file: dv/jlsb_link_top_tb_top.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module jlsb_link_top_tb_top;
  import jlsb_pkg::*;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] r; logic pd;} jlsb_row_t;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic pin = 1'b0;
  logic resync = 1'b0;
  logic sysref, sync_n, pd, busy, spr;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata, div;
  logic [15:0] adc_a = 16'h1234;
  logic [15:0] adc_b = 16'h5678;
  jlsb_link_cfg_t cfg = '{did: 8'h5a, bid: 4'h3, default: '0};
  jlsb_lane_pair_t sym;
  jlsb_lane_pair_t cap [0:255];
  jlsb_phase_t ph;
  int n_fail = 0;
  int samples_checked = 0;
  int n_pulse = 0;
  jlsb_row_t rows [10] = '{'{8'h08, 8'h05, 8'h05, 1'b1}, '{8'h08, 8'h00, 8'h00, 1'b0},
    '{8'h0b, 8'h03, 8'h03, 1'b0}, '{8'hff, 8'h02, 8'h00, 1'b0}, '{8'h10, 8'h55, 8'h00, 1'b0},
    '{8'h3a, 8'h05, 8'h05, 1'b0}, '{8'h5f, 8'h01, 8'h01, 1'b0}, '{8'h5f, 8'h00, 8'h00, 1'b0},
    '{8'hee, 8'h80, 8'h80, 1'b0}, '{8'hef, 8'h80, 8'h80, 1'b0}};
  logic [7:0] ra [7] = '{ADDR_POWER_MODE, ADDR_CLK_DIV, ADDR_REF_SYNC, ADDR_LINK_CTRL,
    ADDR_ADJ_FIRST, ADDR_ADJ_SECOND, ADDR_SOFT_RESET};
  logic [7:0] rv [7] = '{RST_POWER_MODE, RST_CLK_DIV, RST_REF_SYNC, RST_LINK_CTRL,
    RST_ADJ, RST_ADJ, 8'h00};

  always #2 sys_clk = ~sys_clk;
  always @(negedge sys_clk) if (spr === 1'b1) n_pulse++;

  jlsb_link_top #(.SOFT_RST_CYCLES_P(20)) u_dut (.sys_clk_in(sys_clk), .arst_n_in(arst_n),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .power_down_pin_in(pin), .sysref_in(sysref), .sync_n_in(sync_n), .adc_a_in(adc_a),
    .adc_b_in(adc_b), .cfg_in(cfg), .lane_sym_out(sym), .link_phase_out(ph),
    .reg_rdata_out(rdata), .clk_div_active_out(div), .powered_down_out(pd),
    .soft_reset_busy_out(busy), .sample_phase_reset_out(spr));
  jlsb_rx_model u_rx (.clk_in(sys_clk), .rst_n_in(arst_n), .lane_sym_in(sym),
    .subclass1_in(cfg.subclass != 3'h0), .resync_in(resync), .sync_n_out(sync_n),
    .sysref_out(sysref));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    wr = 1'b1; addr = a; wdata = d;
    @(negedge sys_clk); wr = 1'b0;
    @(negedge sys_clk);
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    rd = 1'b1; addr = a;
    @(negedge sys_clk); rd = 1'b0; v = rdata;
    @(negedge sys_clk);
  endtask : rd_reg
  task automatic wait_ph(input jlsb_phase_t p);
    for (int i = 0; i < 3000 && ph !== p; i++) @(negedge sys_clk);
    chk(9'(ph), 9'(p));
  endtask : wait_ph
  task automatic ilas_check;
    logic [7:0] o [0:13];
    jlsb_phase_t mid;
    wait_ph(PH_ILAS);
    for (int i = 0; i < 256; i++) begin
      @(negedge sys_clk); cap[i] = sym;
      if (i == 250) mid = ph;
    end
    chk(9'(mid), 9'(PH_ILAS));
    chk(9'(ph), 9'(PH_DATA));
    for (int l = 0; l < 2; l++) begin
      o = '{cfg.did, {4'h0, cfg.bid}, 8'(l), {cfg.scr_en, 2'b0, 5'(P_L - 1)}, 8'(P_F - 1),
        8'(P_K - 1), 8'(P_M - 1), {cfg.cs, 1'b0, 5'(P_N - 1)}, {cfg.subclass, 5'(P_NP - 1)},
        {3'(P_JESDV), 5'(P_S - 1)}, {1'(P_HD), 2'b0, 5'(P_CF)}, 8'h00, 8'h00, 8'h00};
      o[13] = 8'(cfg.did + cfg.bid + l + cfg.scr_en + P_L - 1 + P_F - 1 + P_K - 1 + P_M - 1
        + cfg.cs + P_N - 1 + cfg.subclass + P_NP - 1 + P_JESDV + P_S - 1 + P_HD + P_CF);
      for (int i = 0; i < 4; i++) begin
        chk(cap[i * 64][l], {1'b1, K_START_MF});
        chk(cap[i * 64 + 63][l], {1'b1, K_LANE_ALIGN});
      end
      chk(cap[65][l], {1'b1, K_CFG_MARK});
      for (int i = 0; i < 14; i++) chk(cap[66 + i][l], {1'b0, o[i]});
    end
  endtask : ilas_check
  task automatic restart(input logic [2:0] sc, input logic s);
    wr_reg(ADDR_LINK_CTRL, 8'h01);
    @(negedge sys_clk);
    chk(9'(ph), 9'(PH_OFF));
    chk(sym[0], 9'h000);
    cfg.subclass = sc; cfg.scr_en = s; resync = 1'b1;
    cfg.cs = {sc[0], s};
    @(negedge sys_clk); resync = 1'b0;
    wr_reg(ADDR_LINK_CTRL, 8'h00);
    wait_ph(PH_CGS);
    @(negedge sys_clk);
    chk(sym[0], {1'b1, K_COMMA});
    ilas_check;
  endtask : restart

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    n_fail++;
    close_out;
  end
  initial begin
    int nf, nh, p;
    logic [7:0] v;
    repeat (3) @(negedge sys_clk);
    arst_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    for (int i = 0; i < 7; i++) begin
      rd_reg(ra[i], v); chk(9'(v), 9'(rv[i]));
    end
    foreach (rows[i]) begin
      wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].a, v); chk(9'(v), 9'(rows[i].r));
      chk(9'(pd), 9'(rows[i].pd));
    end
    chk(9'(div), 9'h000);
    wr_reg(ADDR_COMMIT, CMD_COMMIT);
    chk(9'(div), 9'h003);
    pin = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk(9'(pd), 9'h001);
    chk(9'(ph), 9'(PH_OFF));
    pin = 1'b0;
    repeat (8) @(negedge sys_clk);
    wr_reg(ADDR_ALIGN, CMD_ALIGN);
    repeat (6 * P_K * P_F) @(negedge sys_clk);
    for (int i = 8'h81; i <= 8'h87; i++) begin
      wr_reg(ADDR_ADJ_FIRST, 8'(i));
      wr_reg(ADDR_ADJ_SECOND, 8'(i));
      rd_reg(ADDR_ADJ_FIRST, v); chk(9'(v), 9'(i));
      rd_reg(ADDR_ADJ_SECOND, v); chk(9'(v), 9'(i));
    end
    repeat (6 * P_K * P_F) @(negedge sys_clk);
    restart(3'h0, 1'b0);
    repeat (64) @(negedge sys_clk);
    nf = 0; nh = 0;
    for (int i = 0; i < 64; i++) begin
      @(negedge sys_clk);
      if (sym[0] === {1'b1, K_FRAME_ALIGN}) nf++;
      if (sym[0] === {1'b0, adc_a[15:8]}) nh++;
      if (i == 63) chk(sym[0], {1'b1, K_LANE_ALIGN});
    end
    chk(9'(nf), 9'd31);
    chk(9'(nh), 9'd32);
    resync = 1'b1;
    @(negedge sys_clk); resync = 1'b0;
    wait_ph(PH_CGS);
    p = n_pulse;
    restart(3'h1, 1'b1);
    chk(9'(n_pulse - p), 9'd1);
    wr_reg(ADDR_REF_SYNC, 8'h04);
    p = n_pulse;
    restart(3'h1, 1'b0);
    chk(9'(n_pulse - p), 9'd0);
    wr_reg(ADDR_SOFT_RESET, CMD_SOFT_RESET);
    chk(9'(busy), 9'h001);
    rd_reg(ADDR_SOFT_RESET, v); chk(9'(v), 9'h001);
    wr_reg(ADDR_POWER_MODE, CMD_POWER_DOWN);
    chk(9'(ph), 9'(PH_OFF));
    repeat (20) @(negedge sys_clk);
    chk(9'(busy), 9'h000);
    rd_reg(ADDR_POWER_MODE, v); chk(9'(v), 9'(RST_POWER_MODE));
    rd_reg(ADDR_REF_SYNC, v); chk(9'(v), 9'(RST_REF_SYNC));
    close_out;
  end
endmodule : jlsb_link_top_tb_top
